// >>> hdl/irq_enable.sv
// peripheral interrupt enable register with wishbone slave
// assumes async request inputs, one 200 MHz clock
`timescale 1ns/1ps
`include "irq_enable_defs.svh"
module irq_enable (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        serial2_rx_req,
	input  wire logic        ext_irq2_req,
	input  wire logic        timer_five_req,
	input  wire logic        timer_four_req,
	input  wire logic        out_cmp_ch4_req,
	input  wire logic        out_cmp_ch3_req,
	input  wire logic        dma_ch2_done_req,
	input  wire logic        in_cap_ch8_req,
	input  wire logic        in_cap_ch7_req,
	input  wire logic        ext_irq1_req,
	output logic      [15:0] cpu_irq_req,
	output logic             irq
);
	irq_gate_if gif ();
	irq_gate u_gate (
		.g (gif.gate)
	);

	irq_enable_pkg::word16_t    enable, next_enable;
	irq_enable_pkg::word16_t    status, next_status;
	irq_enable_pkg::word16_t    mask, next_mask;
	irq_enable_pkg::word16_t    sync1, sync2, req_prev;
	irq_enable_pkg::word16_t    next_cpu_irq;
	irq_enable_pkg::bus_state_t state, next_state;
	logic [31:0]                next_dat;
	logic                       next_irq;
	logic                       next_ack;
	logic [15:0]                raw_req;
	logic                       wr, rd;

	// merge byte lanes 0..1 into a 16-bit register
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		lane_merge = {sel[1] ? d[15:8] : old[15:8],
			sel[0] ? d[7:0] : old[7:0]};
	endfunction

	always_comb begin
		raw_req = 16'h0000;
		raw_req[`BIT_SER2RX] = serial2_rx_req;
		raw_req[`BIT_EXT2]   = ext_irq2_req;
		raw_req[`BIT_TMR5]   = timer_five_req;
		raw_req[`BIT_TMR4]   = timer_four_req;
		raw_req[`BIT_OC4]    = out_cmp_ch4_req;
		raw_req[`BIT_OC3]    = out_cmp_ch3_req;
		raw_req[`BIT_DMA2]   = dma_ch2_done_req;
		raw_req[`BIT_IC8]    = in_cap_ch8_req;
		raw_req[`BIT_IC7]    = in_cap_ch7_req;
		raw_req[`BIT_EXT1]   = ext_irq1_req;
	end

	assign gif.enable  = enable;
	assign gif.request = sync2;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i
		&& state == irq_enable_pkg::BUS_IDLE;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i
		&& state == irq_enable_pkg::BUS_IDLE;

	always_comb begin
		next_state  = state;
		next_ack    = 1'b0;
		next_enable = enable;
		next_mask   = mask;
		next_status = status;
		next_dat    = wb_dat_o;
		case (state)
		irq_enable_pkg::BUS_IDLE: begin
			if (wr || rd) begin
				next_state = irq_enable_pkg::BUS_ACK;
				next_ack   = 1'b1;
			end
		end
		irq_enable_pkg::BUS_ACK: begin
			next_state = irq_enable_pkg::BUS_IDLE;
		end
		default: begin
			next_state = irq_enable_pkg::BUS_IDLE;
		end
		endcase
		if (wr) begin
			case (wb_adr_i)
			`ADR_ENABLE: begin
				// bit 5 and unlisted bits keep no value
				next_enable = lane_merge(enable, wb_dat_i, wb_sel_i)
					& `ENABLE_WMASK;
			end
			`ADR_MASK: begin
				next_mask = lane_merge(mask, wb_dat_i, wb_sel_i)
					& `ENABLE_WMASK;
			end
			`ADR_STATUS: begin
				next_status = status
					& ~lane_merge(16'h0000, wb_dat_i, wb_sel_i);
			end
			default: begin
			end
			endcase
		end
		// new request edge wins over a clear
		next_status = next_status | (gif.gated & ~req_prev);
		if (rd) begin
			case (wb_adr_i)
			`ADR_ENABLE: next_dat = {16'h0000, enable};
			`ADR_STATUS: next_dat = {16'h0000, status};
			`ADR_MASK:   next_dat = {16'h0000, mask};
			`ADR_GATED:  next_dat = {16'h0000, gif.gated};
			default:     next_dat = 32'h0000_0000;
			endcase
		end
		next_cpu_irq = gif.gated;
		next_irq     = |(next_status & mask);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state    <= irq_enable_pkg::BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			enable   <= `ENABLE_RESET;
			mask     <= `MASK_RESET;
			status   <= `STATUS_RESET;
			sync1    <= 16'h0000;
			sync2    <= 16'h0000;
			req_prev <= 16'h0000;
			cpu_irq_req <= 16'h0000;
			irq      <= 1'b0;
		end else if (clk_en) begin
			state    <= next_state;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			enable   <= next_enable;
			mask     <= next_mask;
			status   <= next_status;
			sync1    <= raw_req;
			sync2    <= sync1;
			req_prev <= gif.gated;
			cpu_irq_req <= next_cpu_irq;
			irq      <= next_irq;
		end
	end

	a_dma2_gate: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en |=> cpu_irq_req[`BIT_DMA2] ==
		$past(enable[`BIT_DMA2] && sync2[`BIT_DMA2]))
		else $error("dma2 gate wrong");
	a_oc3_gate: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && !enable[`BIT_OC3] |=> !cpu_irq_req[`BIT_OC3])
		else $error("oc3 passed while disabled");
	a_oc3_pass: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && enable[`BIT_OC3] && sync2[`BIT_OC3]
		|=> cpu_irq_req[`BIT_OC3])
		else $error("oc3 not passed");
	a_ext1_gate: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && enable[`BIT_EXT1] && sync2[`BIT_EXT1]
		|=> cpu_irq_req[`BIT_EXT1])
		else $error("ext1 not passed");
	a_ext1_block: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && !enable[`BIT_EXT1] |=> !cpu_irq_req[`BIT_EXT1])
		else $error("ext1 passed while disabled");
	a_bit5_zero: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		!enable[`BIT_UNIMPL] && !cpu_irq_req[`BIT_UNIMPL])
		else $error("bit 5 holds a value");
	a_bit5_read: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		!wb_dat_o[`BIT_UNIMPL])
		else $error("bit 5 read as one");
	a_mask_gate: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en |=> cpu_irq_req == $past(enable & sync2))
		else $error("gated requests wrong");
	a_others_gate: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en |=> (cpu_irq_req & 16'h7CC0)
		== $past(enable & sync2 & 16'h7CC0))
		else $error("other sources wrong");
	a_write_enable: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && wr && wb_adr_i == `ADR_ENABLE && wb_sel_i[1:0] == 2'b11
		|=> enable == ($past(wb_dat_i[15:0]) & `ENABLE_WMASK))
		else $error("enable write lost");
	// a frozen clock holds ack, so only a running cycle must drop it
	a_ack_single: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		(wr || rd) && clk_en |=> wb_ack_o)
		else $error("request not answered");
	a_freeze_hold: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		!clk_en |=> $stable(cpu_irq_req) && $stable(enable)
		&& $stable(status))
		else $error("state moved while frozen");
	a_irq_level: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en |=> irq == |(status & $past(mask)))
		else $error("irq level wrong");
	// status bits only fall through a clearing write
	a_status_keep: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && !(wr && wb_adr_i == `ADR_STATUS)
		|=> (status & $past(status)) == $past(status))
		else $error("status bit lost");
endmodule

// >>> hdl/irq_enable_defs.svh
// constants of the peripheral interrupt enable block
// assumes inclusion by bare name from hdl/
`ifndef IRQ_ENABLE_DEFS_SVH
`define IRQ_ENABLE_DEFS_SVH
`define ADR_ENABLE      4'h0
`define ADR_STATUS      4'h4
`define ADR_MASK        4'h8
`define ADR_GATED       4'hC
`define ENABLE_RESET    16'h0000
`define ENABLE_WMASK    16'h7FD0
`define BIT_DMA2        8
`define BIT_OC3         9
`define BIT_EXT1        4
`define BIT_UNIMPL      5
`define BIT_SER2RX      14
`define BIT_EXT2        13
`define BIT_TMR5        12
`define BIT_TMR4        11
`define BIT_OC4         10
`define BIT_IC8         7
`define BIT_IC7         6
`define STATUS_RESET    16'h0000
`define MASK_RESET      16'h0000
`endif

// >>> hdl/irq_enable_pkg.sv
// types of the peripheral interrupt enable block
// assumes no surroundings
package irq_enable_pkg;
	typedef logic [15:0] word16_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_state_t;
endpackage

// >>> hdl/irq_gate.sv
// per-source gating of peripheral requests
// assumes requests already synchronised by the caller
`timescale 1ns/1ps
`include "irq_enable_defs.svh"
module irq_gate (
	irq_gate_if.gate g
);
	always_comb begin
		// enable bit and request per source, bit 5 never passes
		g.gated = g.enable & g.request & `ENABLE_WMASK;
	end
endmodule

// >>> hdl/irq_gate_if.sv
// bundle between the register front end and the gate
// assumes one clock domain
`timescale 1ns/1ps
interface irq_gate_if;
	logic [15:0] enable;
	logic [15:0] request;
	logic [15:0] gated;
	modport regs (output enable, output request, input gated);
	modport gate (input enable, input request, output gated);
endinterface

// >>> verif/irq_source_model.sv
// peripheral request sources feeding the enable block
// assumes the bench sets one level per enable bit position
`timescale 1ns/1ps
module irq_source_model (
	input  wire logic [15:0] level,
	output logic             serial2_rx_req,
	output logic             ext_irq2_req,
	output logic             timer_five_req,
	output logic             timer_four_req,
	output logic             out_cmp_ch4_req,
	output logic             out_cmp_ch3_req,
	output logic             dma_ch2_done_req,
	output logic             in_cap_ch8_req,
	output logic             in_cap_ch7_req,
	output logic             ext_irq1_req
);
	// each source sits at the bit position of its enable
	assign {serial2_rx_req, ext_irq2_req, timer_five_req, timer_four_req,
		out_cmp_ch4_req, out_cmp_ch3_req, dma_ch2_done_req,
		in_cap_ch8_req, in_cap_ch7_req} = level[14:6];
	assign ext_irq1_req = level[4];
endmodule

// >>> verif/tb.sv
// self-checking bench of the interrupt enable block
// assumes one 200 MHz clock and a classic wishbone master
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        wb_cyc  = 1'b0;
	logic        wb_stb  = 1'b0;
	logic        wb_we   = 1'b0;
	logic [3:0]  wb_adr  = 4'h0;
	logic [31:0] wb_dat  = 32'h0;
	logic [15:0] level   = 16'h0;
	logic        clk_en  = 1'b1;
	logic [3:0]  wb_sel  = 4'h3;
	logic [15:0] held;
	logic [15:0] en;
	logic [31:0] q;
	logic [31:0] d;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [15:0] cpu_irq_req;
	logic        irq;
	wire         s2, e2, t5, t4, o4, o3, d2, i8, i7, e1;
	int          err_total = 0;
	int          compares  = 0;
	int          seed      = 32'h371b;
	localparam logic [15:0] IMPL = 16'h7FD0; // bits that exist

	always #2.5 ref_clk = ~ref_clk;

	irq_source_model i_irq_source_model (.level(level),
		.serial2_rx_req(s2), .ext_irq2_req(e2), .timer_five_req(t5),
		.timer_four_req(t4), .out_cmp_ch4_req(o4), .out_cmp_ch3_req(o3),
		.dma_ch2_done_req(d2), .in_cap_ch8_req(i8), .in_cap_ch7_req(i7),
		.ext_irq1_req(e1));
	irq_enable i_irq_enable (.ref_clk(ref_clk), .rst_n(rst_n),
		.clk_en(clk_en), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.serial2_rx_req(s2), .ext_irq2_req(e2), .timer_five_req(t5),
		.timer_four_req(t4), .out_cmp_ch4_req(o4), .out_cmp_ch3_req(o3),
		.dma_ch2_done_req(d2), .in_cap_ch8_req(i8), .in_cap_ch7_req(i7),
		.ext_irq1_req(e1), .cpu_irq_req(cpu_irq_req), .irq(irq));

	task summarize;
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task wb(input logic w, input logic [3:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_dat <= v;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			summarize();
		end
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		wb(1'b0, 4'h0, 32'h0);
		`CHK(q, 32'h0)
		for (int i = 0; i < 24; i++) begin
			d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
			en = d[15:0] & IMPL;
			wb(1'b1, 4'h0, d);
			wb(1'b0, 4'h0, 32'h0);
			`CHK(q, {16'h0, en})
			level <= 16'($random(seed));
			repeat (5) @(posedge ref_clk);
			`CHK(cpu_irq_req, level & en)
		end
		// frozen clock enable holds the gated outputs
		held = cpu_irq_req;
		clk_en <= 1'b0;
		level <= ~level;
		repeat (5) @(posedge ref_clk);
		`CHK(cpu_irq_req, held)
		clk_en <= 1'b1;
		repeat (5) @(posedge ref_clk);
		`CHK(cpu_irq_req, level & en)
		// low byte lane only: upper enables keep their value
		wb_sel <= 4'h1;
		wb(1'b1, 4'h0, 32'hFFFF);
		en = {en[15:8], 8'hD0};
		wb(1'b0, 4'h0, 32'h0);
		`CHK(q, {16'h0, en})
		wb_sel <= 4'h3;
		// sticky status, mask and level interrupt
		wb(1'b1, 4'h0, {16'h0, IMPL});
		level <= 16'h0;
		repeat (5) @(posedge ref_clk);
		wb(1'b1, 4'h4, 32'hFFFF);
		wb(1'b1, 4'h8, 32'hFFFF);
		d = $random(seed) | 32'h0100;
		level <= d[15:0];
		repeat (6) @(posedge ref_clk);
		wb(1'b0, 4'h4, 32'h0);
		`CHK(q[15:0], d[15:0] & IMPL)
		`CHK(irq, 1'b1)
		wb(1'b0, 4'hC, 32'h0);
		`CHK(q[15:0], d[15:0] & IMPL)
		wb(1'b1, 4'h8, 32'h0);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		wb(1'b1, 4'h4, 32'hFFFF);
		wb(1'b0, 4'h4, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, 4'h2, 32'h0);
		`CHK(q, 32'h0)
		summarize();
	end
endmodule
